// ### src/tkadc_top.sv
// Touch-key and converter register interface, top level.
// Assumes synchronous register port, pad pulses and converter result inputs.
`timescale 1ns/1ps
module tkadc_top (
   input  wire logic        i_clk_sys,
   input  wire logic        i_nrst,
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [7:0]       o_rdata,
   input  wire logic        i_pad_pulse,
   input  wire logic        i_conv_done,
   input  wire logic [11:0] i_conv_data,
   output logic             o_touch_enable,
   output logic [3:0]       o_touch_channel,
   output logic [3:0]       o_conv_channel,
   output logic             o_conv_channel_valid,
   output logic             o_low_supply,
   output logic [1:0]       o_irq_priority,
   output logic             o_irq
);
   tkadc_pkg::tkadc_cfg_t cfg;
   tkadc_pkg::tkadc_cfg_t next_cfg;
   tkadc_pkg::tkadc_res_t res;
   tkadc_pkg::tkadc_res_t next_res;
   logic [7:0]  irq_en_reg;
   logic [7:0]  next_irq_en_reg;
   logic [3:0]  conv_channel;
   logic [3:0]  next_conv_channel;
   logic [7:0]  irq_ctl;
   logic [7:0]  next_irq_ctl;
   logic [1:0]  irq_status;
   logic [1:0]  next_irq_status;
   logic [1:0]  irq_mask;
   logic [1:0]  next_irq_mask;
   logic [7:0]  next_rdata;
   logic        start;
   logic        busy;
   logic        done_pulse;
   logic [11:0] touch_count;

   // ----------------------------------------
   // Decode helper
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------
   // Conversion engine
   // ----------------------------------------
   assign start = i_wr && hit(i_addr, tkadc_pkg::OFS_CONV_START) && i_wdata[0];

   tkadc_conv u_conv (
      .i_clk_sys    (i_clk_sys),
      .i_nrst       (i_nrst),
      .i_start      (start),
      .i_cfg        (cfg),
      .i_pad_pulse  (i_pad_pulse),
      .o_busy       (busy),
      .o_done_pulse (done_pulse),
      .o_count      (touch_count)
   );

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_comb begin
      next_cfg          = cfg;
      next_irq_en_reg   = irq_en_reg;
      next_conv_channel = conv_channel;
      next_irq_ctl      = irq_ctl;
      next_irq_mask     = irq_mask;
      if (i_wr) begin
         if (hit(i_addr, tkadc_pkg::OFS_EXTRA_IRQ_EN)) begin
            next_irq_en_reg = i_wdata;
         end
         if (hit(i_addr, tkadc_pkg::OFS_TOUCH_CONTROL)) begin
            next_cfg.power_down = i_wdata[tkadc_pkg::BIT_POWER_DOWN];
            next_cfg.low_supply = i_wdata[tkadc_pkg::BIT_LOW_SUPPLY];
            next_cfg.slow       = i_wdata[tkadc_pkg::BIT_SLOW];
            next_cfg.ref_cap    = i_wdata[2:0];
         end
         if (hit(i_addr, tkadc_pkg::OFS_CHANNEL_SELECT)) begin
            next_conv_channel   = i_wdata[7:4];
            next_cfg.touch_channel = i_wdata[3:0];
         end
         if (hit(i_addr, tkadc_pkg::OFS_REF_LOW)) begin
            next_cfg.ref_count[7:0] = i_wdata;
         end
         if (hit(i_addr, tkadc_pkg::OFS_REF_HIGH)) begin
            next_cfg.ref_count[11:8] = i_wdata[3:0];
         end
         if (hit(i_addr, tkadc_pkg::OFS_IRQ_CONTROL)) begin
            next_irq_ctl = i_wdata;
         end
         if (hit(i_addr, tkadc_pkg::OFS_IRQ_MASK)) begin
            next_irq_mask = i_wdata[1:0];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         cfg.power_down    <= 1'b1;
         cfg.low_supply    <= 1'b0;
         cfg.slow          <= 1'b0;
         cfg.ref_cap       <= tkadc_pkg::RST_REF_CAP;
         cfg.touch_channel <= tkadc_pkg::RST_TOUCH_CHANNEL;
         cfg.ref_count     <= {tkadc_pkg::RST_REF_HIGH, tkadc_pkg::RST_REF_LOW};
         irq_en_reg        <= 8'h00;
         conv_channel      <= tkadc_pkg::RST_CONV_CHANNEL;
         irq_ctl           <= 8'h00;
         irq_mask          <= 2'h0;
      end else begin
         cfg          <= next_cfg;
         irq_en_reg   <= next_irq_en_reg;
         conv_channel <= next_conv_channel;
         irq_ctl      <= next_irq_ctl;
         irq_mask     <= next_irq_mask;
      end
   end

   // ----------------------------------------
   // Results and event flags
   // ----------------------------------------
   always_comb begin
      next_res            = res;
      // Done rises with the status flag, not a cycle after it
      next_res.touch_done = (!busy || done_pulse) && !(start && !cfg.power_down && !busy);
      next_res.touch_count = touch_count;
      if (i_conv_done) begin
         next_res.conv_result = i_conv_data;
      end
      next_irq_status = irq_status;
      if (i_wr && hit(i_addr, tkadc_pkg::OFS_IRQ_STATUS)) begin
         next_irq_status = irq_status & ~i_wdata[1:0];
      end
      // Set beats a same-cycle clear
      if (done_pulse) begin
         next_irq_status[tkadc_pkg::BIT_EV_TOUCH] = 1'b1;
      end
      if (i_conv_done) begin
         next_irq_status[tkadc_pkg::BIT_EV_CONV] = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         res        <= '{touch_count: 12'h000, conv_result: 12'h000, touch_done: 1'b1};
         irq_status <= 2'h0;
      end else begin
         res        <= next_res;
         irq_status <= next_irq_status;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            tkadc_pkg::OFS_EXTRA_IRQ_EN:   next_rdata = irq_en_reg;
            tkadc_pkg::OFS_SHARED_NIBBLES: next_rdata = {res.conv_result[3:0], res.touch_count[11:8]};
            tkadc_pkg::OFS_CONV_HIGH:      next_rdata = res.conv_result[11:4];
            tkadc_pkg::OFS_TOUCH_LOW:      next_rdata = res.touch_count[7:0];
            tkadc_pkg::OFS_TOUCH_CONTROL:  next_rdata = {cfg.power_down, res.touch_done, cfg.low_supply,
                                                         cfg.slow, 1'b0, cfg.ref_cap};
            tkadc_pkg::OFS_CHANNEL_SELECT: next_rdata = {conv_channel, cfg.touch_channel};
            tkadc_pkg::OFS_REF_LOW:        next_rdata = cfg.ref_count[7:0];
            tkadc_pkg::OFS_REF_HIGH:       next_rdata = {4'h0, cfg.ref_count[11:8]};
            tkadc_pkg::OFS_IRQ_CONTROL:    next_rdata = irq_ctl;
            tkadc_pkg::OFS_IRQ_STATUS:     next_rdata = {6'h00, irq_status};
            tkadc_pkg::OFS_IRQ_MASK:       next_rdata = {6'h00, irq_mask};
            default:                       next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_touch_enable       = !cfg.power_down;
   assign o_touch_channel      = cfg.touch_channel;
   assign o_conv_channel       = conv_channel;
   // Codes 11xx select nothing
   assign o_conv_channel_valid = (conv_channel[3:2] != 2'b11);
   assign o_low_supply         = cfg.low_supply;
   assign o_irq_priority       = {irq_ctl[tkadc_pkg::BIT_PRIO_HIGH], irq_ctl[tkadc_pkg::BIT_PRIO_LOW]};
   assign o_irq = irq_ctl[tkadc_pkg::BIT_GLOBAL_EN] && irq_en_reg[tkadc_pkg::BIT_IRQ_EN]
                  && |(irq_status & irq_mask);
endmodule

// ### src/tkadc_pkg.sv
// Package for the touch-key / converter register interface.
// Assumes one 10 MHz system clock and an 8-bit register port.
package tkadc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_EXTRA_IRQ_EN   = 8'ha9;
   localparam logic [7:0] OFS_SHARED_NIBBLES = 8'haa;
   localparam logic [7:0] OFS_CONV_HIGH      = 8'hab;
   localparam logic [7:0] OFS_TOUCH_LOW      = 8'hac;
   localparam logic [7:0] OFS_TOUCH_CONTROL  = 8'had;
   localparam logic [7:0] OFS_CHANNEL_SELECT = 8'hae;
   localparam logic [7:0] OFS_REF_LOW        = 8'hb4;
   localparam logic [7:0] OFS_REF_HIGH       = 8'hb5;
   localparam logic [7:0] OFS_IRQ_CONTROL    = 8'hf0;
   localparam logic [7:0] OFS_IRQ_STATUS     = 8'hf1;
   localparam logic [7:0] OFS_IRQ_MASK       = 8'hf2;
   localparam logic [7:0] OFS_CONV_START     = 8'hf3;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_IRQ_EN      = 3;
   localparam int BIT_POWER_DOWN  = 7;
   localparam int BIT_DONE        = 6;
   localparam int BIT_LOW_SUPPLY  = 5;
   localparam int BIT_SLOW        = 4;
   localparam int BIT_GLOBAL_EN   = 7;
   localparam int BIT_PRIO_HIGH   = 1;
   localparam int BIT_PRIO_LOW    = 0;
   localparam int BIT_EV_TOUCH    = 0;
   localparam int BIT_EV_CONV     = 1;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [3:0] RST_CONV_CHANNEL  = 4'hf;
   localparam logic [3:0] RST_TOUCH_CHANNEL = 4'hf;
   localparam logic [2:0] RST_REF_CAP       = 3'h4;
   localparam logic [7:0] RST_REF_LOW       = 8'hff;
   localparam logic [3:0] RST_REF_HIGH      = 4'h0;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ            = 10_000_000;
   localparam int REFCLK_NORMAL_HZ  = 1_000_000;
   localparam int REFCLK_NORMAL_DIV = CLK_HZ / REFCLK_NORMAL_HZ;
   localparam int SLOW_FACTOR       = 4;
   localparam int CONV_CYCLES       = 16;

   typedef struct packed {
      logic        power_down;
      logic        low_supply;
      logic        slow;
      logic [2:0]  ref_cap;
      logic [3:0]  touch_channel;
      logic [11:0] ref_count;
   } tkadc_cfg_t;

   typedef struct packed {
      logic [11:0] touch_count;
      logic [11:0] conv_result;
      logic        touch_done;
   } tkadc_res_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_LOAD = 2'b10
   } tkadc_state_t;
endpackage

// ### src/tkadc_rck_div.sv
// Reference clock enable divider for the touch counter.
// Assumes the single system clock; emits one-cycle enable pulses.
`timescale 1ns/1ps
module tkadc_refclk_div (
   input  wire logic       i_clk_sys,
   input  wire logic       i_nrst,
   input  wire logic       i_run,
   input  wire logic       i_slow,
   input  wire logic [2:0] i_ref_cap,
   output logic            o_refclk_en
);
   // Nine bits: the slowest setting needs 320 system cycles per period
   logic [8:0] count;
   logic [8:0] next_count;
   logic [8:0] limit;

   // ----------------------------------------
   // Divide ratio
   // ----------------------------------------
   always_comb begin
      // Larger capacitor code, slower clock slow bit stretches further
      limit = 9'((tkadc_pkg::REFCLK_NORMAL_DIV * (32'(i_ref_cap) + 1) *
                  (i_slow ? tkadc_pkg::SLOW_FACTOR : 1)) - 1);
      next_count = count;
      if (!i_run) begin
         next_count = 9'h000;
      end else if (count >= limit) begin
         next_count = 9'h000;
      end else begin
         next_count = count + 9'h001;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         count <= 9'h000;
      end else begin
         count <= next_count;
      end
   end

   assign o_refclk_en = i_run && (count >= limit);
endmodule

// ### src/tkadc_conv.sv
// Touch conversion engine: reference window, pad count, result load.
// Assumes pad oscillator edges arrive as synchronous one-cycle pulses.
`timescale 1ns/1ps
module tkadc_conv (
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_nrst,
   input  wire logic                    i_start,
   input  wire tkadc_pkg::tkadc_cfg_t   i_cfg,
   input  wire logic                    i_pad_pulse,
   output logic                         o_busy,
   output logic                         o_done_pulse,
   output logic [11:0]                  o_count
);
   tkadc_pkg::tkadc_state_t state;
   tkadc_pkg::tkadc_state_t next_state;
   logic [11:0] ref_left;
   logic [11:0] next_ref_left;
   logic [11:0] acc;
   logic [11:0] next_acc;
   logic [11:0] next_count;
   logic        refclk_en;

   tkadc_refclk_div u_div (
      .i_clk_sys   (i_clk_sys),
      .i_nrst      (i_nrst),
      .i_run       (state == tkadc_pkg::ST_RUN),
      .i_slow      (i_cfg.slow),
      .i_ref_cap   (i_cfg.ref_cap),
      .o_refclk_en (refclk_en)
   );

   // ----------------------------------------
   // Conversion sequence
   // ----------------------------------------
   always_comb begin
      next_state    = state;
      next_ref_left = ref_left;
      next_acc      = acc;
      next_count    = o_count;
      unique case (state)
         tkadc_pkg::ST_IDLE: begin
            // Powered-down unit ignores starts
            if (i_start && !i_cfg.power_down) begin
               next_state    = tkadc_pkg::ST_RUN;
               next_ref_left = i_cfg.ref_count;
               next_acc      = 12'h000;
            end
         end
         tkadc_pkg::ST_RUN: begin
            if (i_pad_pulse && acc != 12'hfff) begin
               next_acc = acc + 12'h001;
            end
            if (i_cfg.power_down) begin
               next_state = tkadc_pkg::ST_IDLE;
            end else if (refclk_en) begin
               if (ref_left == 12'h000) begin
                  // Count lands on entry to LOAD, ahead of the done flag
                  next_state = tkadc_pkg::ST_LOAD;
                  next_count = next_acc;
               end else begin
                  next_ref_left = ref_left - 12'h001;
               end
            end
         end
         tkadc_pkg::ST_LOAD: begin
            next_count = acc;
            next_state = tkadc_pkg::ST_IDLE;
         end
         default: begin
            next_state = tkadc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         state    <= tkadc_pkg::ST_IDLE;
         ref_left <= 12'h000;
         acc      <= 12'h000;
         o_count  <= 12'h000;
      end else begin
         state    <= next_state;
         ref_left <= next_ref_left;
         acc      <= next_acc;
         o_count  <= next_count;
      end
   end

   // Count stored on the same edge that raises the done pulse
   assign o_busy       = (state != tkadc_pkg::ST_IDLE);
   assign o_done_pulse = (state == tkadc_pkg::ST_LOAD);
endmodule

// ### bench/tkadc_chk.sv
// Port checker for the touch-key and converter register block.
// Assumes it is bound to tkadc_top and sees only that module's ports.
`timescale 1ns/1ps
module tkadc_chk (
   input wire logic        i_clk_sys,
   input wire logic        i_nrst,
   input wire logic [7:0]  i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  o_rdata,
   input wire logic        i_conv_done,
   input wire logic [11:0] i_conv_data,
   input wire logic        o_touch_enable,
   input wire logic [3:0]  o_touch_channel,
   input wire logic [3:0]  o_conv_channel,
   input wire logic        o_conv_channel_valid,
   input wire logic        o_low_supply,
   input wire logic [1:0]  o_irq_priority,
   input wire logic        o_irq
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // ------
   // Register fields reach the ports
   // ------
   chk_pd_enable:
   assert property (i_wr && i_addr == 8'had |=> o_touch_enable == !$past(i_wdata[7])) else $error("touch enable");
   chk_low_supply:
   assert property (i_wr && i_addr == 8'had |=> o_low_supply == $past(i_wdata[5])) else $error("low supply");
   chk_touch_chan:
   assert property (i_wr && i_addr == 8'hae |=> o_touch_channel == $past(i_wdata[3:0])) else $error("touch chan");
   chk_conv_chan:
   assert property (i_wr && i_addr == 8'hae |=> o_conv_channel == $past(i_wdata[7:4])) else $error("conv chan");
   chk_chan_valid:
   assert property (o_conv_channel_valid == (o_conv_channel[3:2] != 2'b11)) else $error("chan valid");
   chk_chan_hold:
   assert property (!(i_wr && i_addr == 8'hae) |=> $stable(o_touch_channel)) else $error("chan moved");
   // ------
   // Interrupt gating and result path
   // ------
   chk_global_off:
   assert property (i_wr && i_addr == 8'hf0 && !i_wdata[7] |=> !o_irq) else $error("irq past global");
   chk_enable_off:
   assert property (i_wr && i_addr == 8'ha9 && !i_wdata[3] |=> !o_irq) else $error("irq past enable");
   chk_prio_set:
   assert property (i_wr && i_addr == 8'hf0 |=> o_irq_priority == $past(i_wdata[1:0])) else $error("priority");
   chk_conv_read:
   assert property (i_conv_done ##1 (i_rd && i_addr == 8'hab && !i_conv_done)
      |=> {o_rdata, 4'h0} == ($past(i_conv_data, 2) & 12'hff0)) else $error("conv result");
endmodule

bind tkadc_top tkadc_chk u_chk (
   .i_clk_sys           (i_clk_sys),
   .i_nrst              (i_nrst),
   .i_addr              (i_addr),
   .i_wdata             (i_wdata),
   .i_wr                (i_wr),
   .i_rd                (i_rd),
   .o_rdata             (o_rdata),
   .i_conv_done         (i_conv_done),
   .i_conv_data         (i_conv_data),
   .o_touch_enable      (o_touch_enable),
   .o_touch_channel     (o_touch_channel),
   .o_conv_channel      (o_conv_channel),
   .o_conv_channel_valid(o_conv_channel_valid),
   .o_low_supply        (o_low_supply),
   .o_irq_priority      (o_irq_priority),
   .o_irq               (o_irq)
);

// ### bench/tkadc_pad_model.sv
// Pad oscillator model feeding the touch counter.
// Assumes one system clock; a burst request sets how many edges follow.
`timescale 1ns/1ps
module tkadc_pad_model #(
   parameter int BURST = 5
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_touch_enable,
   input  wire logic [3:0] i_touch_channel,
   input  wire logic       i_burst,
   output logic            o_pad_pulse
);
   int   left;
   logic phase;
   initial begin
      left        = 0;
      phase       = 1'b0;
      o_pad_pulse = 1'b0;
   end
   // ------
   // Disabled or unselected pad stays quiet
   // ------
   always @(posedge i_clk_sys) begin
      phase       <= ~phase;
      o_pad_pulse <= 1'b0;
      if (i_burst) begin
         left <= BURST;
      end else if (left != 0 && phase && i_touch_enable && i_touch_channel != 4'hf) begin
         o_pad_pulse <= 1'b1;
         left        <= left - 1;
      end
   end
endmodule

// ### bench/test_touch_key_adc_sfr_interface.sv
// Self-checking bench for the touch-key and converter register block.
// Assumes the design, its bound checker and the pad model compile first.
`timescale 1ns/1ps
module test_touch_key_adc_sfr_interface;
   logic        i_clk_sys   = 1'b0;
   logic        i_nrst      = 1'b0;
   logic [7:0]  i_addr      = 8'h00;
   logic [7:0]  i_wdata     = 8'h00;
   logic        i_wr        = 1'b0;
   logic        i_rd        = 1'b0;
   logic        i_conv_done = 1'b0;
   logic [11:0] i_conv_data = 12'h000;
   logic        burst       = 1'b0;
   logic        rd_d1       = 1'b0;
   logic [31:0] seed        = 32'h66da;
   logic [31:0] t;
   logic [3:0]  cnib;
   logic        pad, o_touch_enable, o_conv_channel_valid, o_low_supply, o_irq;
   logic [3:0]  o_touch_channel, o_conv_channel;
   logic [1:0]  o_irq_priority;
   logic [7:0]  o_rdata;
   logic [15:0] outs;
   logic [7:0]  exp_q[$];
   int          error_cnt    = 0;
   int          total_checks = 0;
   logic [7:0]  ra[12] = '{8'ha9, 8'haa, 8'hab, 8'hac, 8'had, 8'hae, 8'hb4, 8'hb5, 8'hf0, 8'hf1, 8'hf2, 8'h50};
   logic [7:0]  rv[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hc4, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0]  ia[7]  = '{8'hf0, 8'hf0, 8'ha9, 8'ha9, 8'hf2, 8'hf2, 8'hf1};
   logic [7:0]  id[7]  = '{8'h01, 8'h82, 8'h00, 8'h08, 8'h00, 8'h01, 8'h01};
   logic [3:0]  cf[4]  = '{4'h0, 4'h4, 4'h7, 4'h8};

   always #50 i_clk_sys = ~i_clk_sys;
   assign outs = {2'b00, o_touch_enable, o_touch_channel, o_conv_channel, o_conv_channel_valid,
                  o_low_supply, o_irq_priority, o_irq};

   tkadc_top u_dut (
      .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_pad_pulse(pad), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
      .o_touch_enable(o_touch_enable), .o_touch_channel(o_touch_channel), .o_conv_channel(o_conv_channel),
      .o_conv_channel_valid(o_conv_channel_valid), .o_low_supply(o_low_supply),
      .o_irq_priority(o_irq_priority), .o_irq(o_irq)
   );
   tkadc_pad_model u_pad (
      .i_clk_sys(i_clk_sys), .i_touch_enable(o_touch_enable), .i_touch_channel(o_touch_channel),
      .i_burst(burst), .o_pad_pulse(pad)
   );

   // ------
   // Shared tasks
   // ------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Each access ends with a spare edge so strobes never retoggle in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      i_addr <= a;
      i_rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge i_clk_sys) begin
      rd_d1 <= i_rd;
      if (rd_d1)
         check({8'h00, o_rdata}, {8'h00, exp_q.pop_front()});
   end
   // Reference value 2: three reference periods, then the load cycle
   task automatic convert(input logic [3:0] c);
      int p;
      int k;
      p = 10 * (int'(c[2:0]) + 1) * (c[3] ? 4 : 1);
      wr(8'had, {3'b000, c[3], 1'b0, c[2:0]});
      check(outs & 16'h2000, 16'h2000);
      wr(8'hf3, 8'h01);
      burst <= 1'b1;
      rd(8'had, {3'b000, c[3], 1'b0, c[2:0]});
      burst <= 1'b0;
      k = 0;
      while (o_irq !== 1'b1 && k < 3000) begin
         @(negedge i_clk_sys);
         k++;
      end
      @(posedge i_clk_sys);
      check({15'h0, (k + 3 >= 2 * p) && (k + 3 <= 3 * p + 6)}, 16'h0001);
      if (k >= 3000)
         conclude();
      rd(8'hac, 8'h05);
      rd(8'haa, {cnib, 4'h0});
      rd(8'had, {3'b010, c[3], 1'b0, c[2:0]});
   endtask

   initial begin
      repeat (16) @(posedge i_clk_sys);
      check(outs, 16'h1fe0);
      i_nrst <= 1'b1;
      @(posedge i_clk_sys);
      foreach (ra[i]) rd(ra[i], rv[i]);
      for (int i = 1; i < 4; i++) wr(ra[i], 8'hff);
      wr(8'h50, 8'hff);
      for (int i = 1; i < 4; i++) rd(ra[i], 8'h00);
      rd(8'h50, 8'h00);
      for (int i = 0; i < 16; i++) begin
         wr(8'hae, {i[3:0], ~i[3:0]});
         rd(8'hae, {i[3:0], ~i[3:0]});
         check(outs & 16'h1ff0, {3'b000, ~i[3:0], i[3:0], i[3:2] != 2'b11, 4'h0});
      end
      wr(8'had, 8'ha0);
      check(outs & 16'h2008, 16'h0008);
      rd(8'had, 8'he0);
      t = rnd();
      wr(8'hb4, t[7:0]);
      wr(8'hb5, {4'h0, t[11:8]});
      rd(8'hb4, t[7:0]);
      rd(8'hb5, {4'h0, t[11:8]});
      wr(8'hb4, 8'h02);
      wr(8'hb5, 8'h00);
      t = rnd();
      cnib = t[3:0];
      i_conv_data <= t[11:0];
      i_conv_done <= 1'b1;
      @(posedge i_clk_sys);
      i_conv_done <= 1'b0;
      rd(8'hab, t[11:4]);
      rd(8'hf1, 8'h02);
      wr(8'hf1, 8'h02);
      wr(8'hf0, 8'h80);
      wr(8'ha9, 8'h08);
      wr(8'hf2, 8'h01);
      for (int j = 0; j < 4; j++) begin
         convert(cf[j]);
         if (j == 0) begin
            for (int i = 0; i < 7; i++) begin
               wr(ia[i], id[i]);
               check(outs & 16'h0007, {13'h0, i == 0 ? 2'b01 : 2'b10, i[0]});
            end
         end else begin
            wr(8'hf1, 8'h01);
         end
      end
      // Power-down in mid-window must leave no flag behind
      wr(8'had, 8'h00);
      wr(8'hf3, 8'h01);
      wr(8'had, 8'h80);
      wr(8'hf3, 8'h01);
      repeat (200) @(posedge i_clk_sys);
      rd(8'hf1, 8'h00);
      rd(8'had, 8'hc0);
      repeat (3) @(posedge i_clk_sys);
      conclude();
   end
endmodule
